// ### pkg/dprs_params.svh
// Constants of the drive parameter restore sequencer
`ifndef DPRS_PARAMS_SVH
`define DPRS_PARAMS_SVH
`define DPRS_CODE_IDLE       16'h0000
`define DPRS_CODE_ARMED      16'h0001
`define DPRS_CTRL_ERR_CODE   16'h0021
`define DPRS_DELAY_MS        3000
`define DPRS_CLK_KHZ         40000
`define DPRS_DELAY_CYCLES    (`DPRS_DELAY_MS * `DPRS_CLK_KHZ)
`define DPRS_DRIVES          16
`define DPRS_PORT_ETH        8'h03
`define DPRS_PROTO_ETH       8'h01
`define DPRS_NAME_PAD        24'h000000
`endif

// ### pkg/dprs_pkg.sv
// Types of the drive parameter restore sequencer
package dprs_pkg;
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_DELAY = 5'h02,
        ST_SCAN  = 5'h04,
        ST_WAIT  = 5'h08,
        ST_DONE  = 5'h10
    } dprs_state_type;
    typedef struct packed {
        logic [63:0] name;
        logic [31:0] ip;
        logic [7:0]  station;
        logic        pwd_en;
        logic        ignore_chk;
    } dprs_req_type;
endpackage

// ### pkg/dprs_link_if.sv
// Per-drive request and result path to the drive protocol engine
`timescale 1ns/1ps
interface dprs_link_if;
    logic                  req;
    dprs_pkg::dprs_req_type info;
    logic                  done;
    logic                  fail;
    logic [15:0]           code;
    modport seq (output req, output info, input done, input fail,
                 input code);
    modport eng (input req, input info, output done, output fail,
                 output code);
endinterface

// ### src/dprs_name_build.sv
// Backup file name builder: IP bytes, station, zero pad
`timescale 1ns/1ps
`include "dprs_params.svh"
module dprs_name_build
(
    // Drive identity
    input  wire logic [31:0] ip,
    input  wire logic [7:0]  station,
    // File name digits as hex nibbles
    output logic      [63:0] name
);
    assign name = {ip, station, `DPRS_NAME_PAD};
endmodule

// ### src/dprs_delay.sv
// Power-up wait counter
`timescale 1ns/1ps
`include "dprs_params.svh"
module dprs_delay
#(
    parameter int unsigned CYCLES = `DPRS_DELAY_CYCLES
)
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Control
    input  wire logic start,
    input  wire logic abort,
    output logic      expired
);
    logic [31:0] cnt_r;
    logic        run_r;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            cnt_r <= 32'h0;
            run_r <= 1'b0;
        end
        else if (abort)
            run_r <= 1'b0;
        else if (start)
        begin
            cnt_r <= 32'h0;
            run_r <= 1'b1;
        end
        else if (run_r)
        begin
            if (cnt_r == CYCLES - 1)
                run_r <= 1'b0;
            cnt_r <= cnt_r + 32'h1;
        end
    assign expired = run_r && (cnt_r == CYCLES - 1);
endmodule

// ### src/dprs_sequencer.sv
// Drive parameter restore sequencer top
// How it works
// - Code 0 idles; code 1 restores
// - Mask bit n selects drive n+1
// - Count failed drives, zero if none
// - Hold last failing drive IP octet
// - Hold error code of last failure
// - Set done flag on clean finish
// - Set error flag on any failure
// - Code 1 to 0 clears flags
// - Power-up waits configurable delay first
// - Code 0 skips delay and restoration
// - Option halts controller on error
// - Error lights warning, records 0021
// - Per-drive IP, station, password, check settings
// - File name: IP hex, station, zeros
// - Port field 03, protocol field 01
`timescale 1ns/1ps
`include "dprs_params.svh"
module dprs_sequencer
#(
    parameter int unsigned DELAY_CYCLES = `DPRS_DELAY_CYCLES,
    parameter int unsigned DRIVES       = `DPRS_DRIVES
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Register write port
    input  wire logic        code_we,
    input  wire logic [15:0] code_wdata,
    input  wire logic        mask_lo_we,
    input  wire logic        mask_hi_we,
    input  wire logic [15:0] mask_wdata,
    // Controller events
    input  wire logic        modules_ready,
    input  wire logic        stop_to_run,
    // Configuration
    input  wire logic        halt_on_error,
    input  wire logic [31:0] drive_ip [DRIVES],
    input  wire logic [7:0]  drive_station [DRIVES],
    input  wire logic [DRIVES-1:0] drive_pwd_en,
    input  wire logic [DRIVES-1:0] drive_ignore_chk,
    // Drive protocol engine
    output logic        eng_req,
    output logic [63:0] eng_name,
    output logic [31:0] eng_ip,
    output logic [7:0]  eng_station,
    output logic        eng_pwd_en,
    output logic        eng_ignore_chk,
    output logic [7:0]  eng_port,
    output logic [7:0]  eng_proto,
    input  wire logic   eng_done,
    input  wire logic   eng_fail,
    input  wire logic [15:0] eng_code,
    // Register read values
    output logic [15:0] restore_command_code,
    output logic [15:0] restore_target_mask_low,
    output logic [15:0] restore_target_mask_high,
    output logic [15:0] restore_failure_count,
    output logic [15:0] last_failed_ip_octet,
    output logic [15:0] last_failure_code,
    output logic        restore_done_flag,
    output logic        restore_error_flag,
    // Controller status
    output logic        warn_led,
    output logic [15:0] ctrl_error_code,
    output logic        ctrl_halt,
    output logic        busy
);
    typedef struct packed {
        dprs_pkg::dprs_state_type st;
        logic [15:0] code;
        logic [15:0] mlo;
        logic [15:0] mhi;
        logic [15:0] pend;
        logic [4:0]  idx;
        logic [15:0] fcnt;
        logic [7:0]  foct;
        logic [15:0] fcode;
        logic        done;
        logic        err;
        logic        warn;
        logic        halt;
        logic        req;
        logic        pwr_seen;
    } dprs_regs_type;

    dprs_regs_type r, n;
    dprs_link_if   lk ();
    logic          dly_start;
    logic          dly_exp;
    logic          armed;
    logic          abort;
    logic [3:0]    cur;
    logic [63:0]   file_name;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    dprs_delay #(.CYCLES(DELAY_CYCLES)) u_delay
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .start   (dly_start),
        .abort   (abort),
        .expired (dly_exp)
    );

    assign cur = r.idx[3:0];
    // One driver for the whole record keeps its fields free of conflicts
    assign lk.info = {file_name,
                      drive_ip[cur],
                      drive_station[cur],
                      drive_pwd_en[cur],
                      drive_ignore_chk[cur]};
    assign lk.req  = r.req;
    assign lk.done = eng_done;
    assign lk.fail = eng_fail;
    assign lk.code = eng_code;

    dprs_name_build u_name
    (
        .ip      (drive_ip[cur]),
        .station (drive_station[cur]),
        .name    (file_name)
    );

    assign armed = (r.code == `DPRS_CODE_ARMED);
    assign abort = !armed;

    always_comb
    begin
        n = r;
        dly_start = 1'b0;
        if (code_we)
            n.code = code_wdata;
        if (mask_lo_we)
            n.mlo = mask_wdata;
        if (mask_hi_we)
            n.mhi = mask_wdata;
        if (modules_ready)
            n.pwr_seen = 1'b1;
        // Software writes 0 after a run a finishing run still wins
        if (armed && n.code == `DPRS_CODE_IDLE)
        begin
            n.done = 1'b0;
            n.err  = 1'b0;
        end
        // Only the low mask word selects drives; the high word is stored
        case (r.st)
            dprs_pkg::ST_IDLE:
            begin
                // Power-up trigger is one-shot; code 0 skips it
                if (modules_ready && !r.pwr_seen && armed)
                begin
                    dly_start = 1'b1;
                    n.st = dprs_pkg::ST_DELAY;
                end
                else if (stop_to_run && armed)
                    n.st = dprs_pkg::ST_SCAN;
                if (n.st == dprs_pkg::ST_SCAN)
                begin
                    n.pend = r.mlo;
                    n.idx  = 5'h00;
                    n.fcnt = 16'h0000;
                end
            end
            dprs_pkg::ST_DELAY:
            begin
                if (abort)
                    n.st = dprs_pkg::ST_IDLE;
                else if (dly_exp)
                begin
                    n.st = dprs_pkg::ST_SCAN;
                    n.pend = r.mlo;
                    n.idx  = 5'h00;
                    n.fcnt = 16'h0000;
                end
            end
            dprs_pkg::ST_SCAN:
            begin
                if (r.idx >= 5'(DRIVES))
                    n.st = dprs_pkg::ST_DONE;
                else if (r.pend[cur])
                begin
                    n.req = 1'b1;
                    n.st  = dprs_pkg::ST_WAIT;
                end
                else
                    n.idx = r.idx + 5'h01;
            end
            dprs_pkg::ST_WAIT:
            begin
                if (lk.done)
                begin
                    n.req = 1'b0;
                    if (lk.fail)
                    begin
                        n.fcnt  = r.fcnt + 16'h0001;
                        n.foct  = lk.info.ip[7:0];
                        n.fcode = lk.code;
                    end
                    n.idx = r.idx + 5'h01;
                    n.st  = dprs_pkg::ST_SCAN;
                end
            end
            dprs_pkg::ST_DONE:
            begin
                if (r.fcnt != 16'h0000)
                begin
                    n.err  = 1'b1;
                    n.warn = 1'b1;
                    n.halt = halt_on_error;
                end
                else
                    n.done = 1'b1;
                n.st = dprs_pkg::ST_IDLE;
            end
            default:
                n.st = dprs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            r      <= '0;
            r.st   <= dprs_pkg::ST_IDLE;
            r.code <= `DPRS_CODE_IDLE;
        end
        else
            r <= n;

    assign eng_req        = lk.req;
    assign eng_name       = lk.info.name;
    assign eng_ip         = lk.info.ip;
    assign eng_station    = lk.info.station;
    assign eng_pwd_en     = lk.info.pwd_en;
    assign eng_ignore_chk = lk.info.ignore_chk;
    assign eng_port       = `DPRS_PORT_ETH;
    assign eng_proto      = `DPRS_PROTO_ETH;

    assign restore_command_code     = r.code;
    assign restore_target_mask_low  = r.mlo;
    assign restore_target_mask_high = r.mhi;
    assign restore_failure_count    = r.fcnt;
    assign last_failed_ip_octet     = {8'h00, r.foct};
    assign last_failure_code        = r.fcode;
    assign restore_done_flag        = r.done;
    assign restore_error_flag       = r.err;
    assign warn_led        = r.warn;
    assign ctrl_error_code = r.warn ? `DPRS_CTRL_ERR_CODE : 16'h0000;
    assign ctrl_halt       = r.halt;
    assign busy            = (r.st != dprs_pkg::ST_IDLE);

    // Named sequences for the two ways a run can finish
    sequence s_finish_ok;
        (r.st == dprs_pkg::ST_DONE) && (r.fcnt == 16'h0000);
    endsequence
    sequence s_finish_bad;
        (r.st == dprs_pkg::ST_DONE) && (r.fcnt != 16'h0000);
    endsequence

    AST_IDLE_NO_RUN: assert property (
        (r.st == dprs_pkg::ST_IDLE && !armed) |=> r.st != dprs_pkg::ST_SCAN)
        else $error("run started with code 0");
    AST_MASK_SKIP: assert property (
        (r.st == dprs_pkg::ST_SCAN && r.idx < 5'(DRIVES) && !r.pend[cur])
        |=> !r.req)
        else $error("request to unselected drive");
    AST_FAIL_COUNT: assert property (
        (r.st == dprs_pkg::ST_WAIT && lk.done && lk.fail)
        |=> r.fcnt == $past(r.fcnt) + 16'h0001)
        else $error("failure count not bumped");
    AST_FAIL_OCTET: assert property (
        (r.st == dprs_pkg::ST_WAIT && lk.done && lk.fail)
        |=> r.foct == $past(eng_ip[7:0]) && r.fcode == $past(eng_code))
        else $error("failure octet or code not captured");
    AST_DONE_OK: assert property (
        s_finish_ok |=> r.done && (!r.err || $past(r.err)))
        else $error("done flag not set on clean run");
    AST_ERR_SET: assert property (
        s_finish_bad ##1 armed |-> r.err && warn_led
        && ctrl_error_code == `DPRS_CTRL_ERR_CODE)
        else $error("error flag or warning missing");
    AST_FLAG_CLEAR: assert property (
        (armed && r.st != dprs_pkg::ST_DONE) ##1 r.code == `DPRS_CODE_IDLE
        |-> !r.done && !r.err)
        else $error("flags not cleared on code drop");
    AST_HALT_OPT: assert property (
        (s_finish_bad and (!halt_on_error && !r.halt)) |=> !r.halt)
        else $error("halt without option");
    AST_DELAY_WAIT: assert property (
        (r.st == dprs_pkg::ST_DELAY && armed && !dly_exp)
        |=> r.st == dprs_pkg::ST_DELAY)
        else $error("restore began before the power-up delay ran out");
    AST_REQ_HOLD: assert property (
        (r.req && !lk.done) |=> r.req)
        else $error("drive request dropped before its answer");
    AST_WARN_STICKY: assert property (
        warn_led |=> warn_led)
        else $error("warning indicator dropped");
endmodule

// ### test/dprs_drive_model.sv
// Drive protocol engine model answering restore requests
`timescale 1ns/1ps
module dprs_drive_model
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Request side
    input  wire logic        eng_req,
    input  wire logic [31:0] eng_ip,
    input  wire logic [15:0] fail_sel,
    // Answer side
    output logic             eng_done,
    output logic             eng_fail,
    output logic [15:0]      eng_code
);
    logic [3:0] wait_r;
    logic [3:0] idx;
    assign idx = 4'(eng_ip[7:0] - 8'h01);
    // Latency follows the address so prompt and slow answers both occur
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_r   <= 4'h0;
            eng_done <= 1'b0;
            eng_fail <= 1'b0;
            eng_code <= 16'h0000;
        end
        else if (eng_req && !eng_done && wait_r >= {2'b00, eng_ip[1:0]})
        begin
            wait_r   <= 4'h0;
            eng_done <= 1'b1;
            eng_fail <= fail_sel[idx];
            eng_code <= {8'h10, 4'h0, idx};
        end
        else
        begin
            // Result lines toggle every cycle between answers; only eng_done marks them valid
            wait_r   <= eng_req ? wait_r + 4'h1 : 4'h0;
            eng_done <= 1'b0;
            eng_fail <= ~eng_fail;
            eng_code <= ~eng_code;
        end
    end
endmodule

// ### test/drive_parameter_restore_sequencer_tb.sv
// Self-checking bench of the drive parameter restore sequencer
`timescale 1ns/1ps
module drive_parameter_restore_sequencer_tb;
    typedef struct packed {
        logic [15:0] mask;
        logic [15:0] fsel;
        logic [15:0] cnt;
        logic [15:0] oct;
        logic [15:0] code;
        logic [63:0] name;
        logic        done;
        logic        err;
    } dprs_row_type;
    logic        ref_clk = 1'b0, rst = 1'b1, halt_on_error = 1'b0;
    logic        code_we = 1'b0, mask_lo_we = 1'b0, mask_hi_we = 1'b0;
    logic        modules_ready = 1'b0, stop_to_run = 1'b0;
    logic [15:0] code_wdata = 16'h0000, mask_wdata = 16'h0000;
    logic [15:0] fail_sel = 16'h0000;
    logic [31:0] dip [16];
    logic [7:0]  dst [16];
    logic        eng_req, eng_pwd_en, eng_ignore_chk, eng_done, eng_fail;
    logic [63:0] eng_name, nm;
    logic [31:0] eng_ip;
    logic [7:0]  eng_station, eng_port, eng_proto;
    logic [15:0] eng_code, cmd, mlo, mhi, fcnt, oct, lcode, ctrl_error_code;
    logic        done_f, err_f, warn_led, ctrl_halt, busy;
    int          failures = 0, tests_run = 0, t_req;
    localparam logic [15:0] pwd_cfg = 16'hA5A5, chk_cfg = 16'h0FF0;
    dprs_row_type rows [4] = '{
        '{16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
          64'h0A00000101000000, 1'b1, 1'b0},
        '{16'h8025, 16'h0024, 16'h0002, 16'h0006, 16'h1005,
          64'h0A00001010000000, 1'b0, 1'b1},
        '{16'hFFFF, 16'hFFFF, 16'h0010, 16'h0010, 16'h100F,
          64'h0A00001010000000, 1'b0, 1'b1},
        '{16'h0000, 16'hFFFF, 16'h0000, 16'h0000, 16'h0000,
          64'h0000000000000000, 1'b1, 1'b0}};

    always #12.5 ref_clk = ~ref_clk;

    dprs_sequencer #(.DELAY_CYCLES(20), .DRIVES(16)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .code_we(code_we),
        .code_wdata(code_wdata), .mask_lo_we(mask_lo_we),
        .mask_hi_we(mask_hi_we), .mask_wdata(mask_wdata),
        .modules_ready(modules_ready), .stop_to_run(stop_to_run),
        .halt_on_error(halt_on_error), .drive_ip(dip), .drive_station(dst),
        .drive_pwd_en(pwd_cfg), .drive_ignore_chk(chk_cfg),
        .eng_req(eng_req), .eng_name(eng_name), .eng_ip(eng_ip),
        .eng_station(eng_station), .eng_pwd_en(eng_pwd_en),
        .eng_ignore_chk(eng_ignore_chk), .eng_port(eng_port),
        .eng_proto(eng_proto), .eng_done(eng_done), .eng_fail(eng_fail),
        .eng_code(eng_code), .restore_command_code(cmd),
        .restore_target_mask_low(mlo), .restore_target_mask_high(mhi),
        .restore_failure_count(fcnt), .last_failed_ip_octet(oct),
        .last_failure_code(lcode), .restore_done_flag(done_f),
        .restore_error_flag(err_f), .warn_led(warn_led),
        .ctrl_error_code(ctrl_error_code), .ctrl_halt(ctrl_halt),
        .busy(busy));

    dprs_drive_model drv_u (
        .ref_clk(ref_clk), .rst(rst), .eng_req(eng_req), .eng_ip(eng_ip),
        .fail_sel(fail_sel), .eng_done(eng_done), .eng_fail(eng_fail),
        .eng_code(eng_code));

    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // Register write: 0 command code, 1 low mask, 2 high mask
    task automatic wr(input int sel, input logic [15:0] d);
        @(negedge ref_clk);
        code_we = (sel == 0);
        mask_lo_we = (sel == 1);
        mask_hi_we = (sel == 2);
        code_wdata = d;
        mask_wdata = d;
        @(negedge ref_clk);
        code_we = 1'b0;
        mask_lo_we = 1'b0;
        mask_hi_we = 1'b0;
        @(negedge ref_clk);
    endtask

    // Trigger a run, then wait for it under a bounded count
    task automatic run(input logic pwr, input logic [15:0] mask);
        int n;
        int k;
        logic prev;
        n = 0;
        k = 0;
        prev = 1'b0;
        t_req = -1;
        modules_ready = pwr;
        stop_to_run = !pwr;
        @(negedge ref_clk);
        modules_ready = 1'b0;
        stop_to_run = 1'b0;
        while (busy === 1'b1 && n < 3000)
        begin
            if (eng_req === 1'b1)
            begin
                nm = eng_name;
                if (t_req < 0)
                    t_req = n;
            end
            // Each new request must name the next selected drive
            if (eng_req === 1'b1 && prev !== 1'b1)
            begin
                while (k < 16 && !mask[k])
                    k++;
                chk_val({eng_ip, eng_station, eng_pwd_en, eng_ignore_chk},
                        {dip[k], dst[k], pwd_cfg[k], chk_cfg[k]});
                k++;
            end
            prev = eng_req;
            n++;
            @(negedge ref_clk);
        end
        if (n >= 3000)
            chk_flag(busy, 1'b0);
        while (k < 16 && !mask[k])
            k++;
        chk_val(k, 16);
        @(negedge ref_clk);
    endtask

    task automatic wrap_up;
        $display("Checks run %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        #(30000 * 25);
        failures++;
        wrap_up();
    end

    initial
    begin
        for (int i = 0; i < 16; i++)
        begin
            dip[i] = {24'h0A0000, 8'(i + 1)};
            dst[i] = 8'(i + 1);
        end
        repeat (8) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        chk_val(cmd, 16'h0000);
        foreach (rows[i])
        begin
            fail_sel = rows[i].fsel;
            wr(1, rows[i].mask);
            wr(2, ~rows[i].mask);
            wr(0, 16'h0001);
            chk_val({mhi, mlo}, {~rows[i].mask, rows[i].mask});
            run(1'b0, rows[i].mask);
            chk_val(fcnt, rows[i].cnt);
            if (rows[i].err)
            begin
                chk_val(oct, rows[i].oct);
                chk_val(lcode, rows[i].code);
            end
            if (rows[i].mask != 16'h0000)
                chk_val({nm, eng_port, eng_proto},
                        {rows[i].name, 16'h0301});
            chk_flag(done_f, rows[i].done);
            chk_flag(err_f, rows[i].err);
            wr(0, 16'h0000);
            @(negedge ref_clk);
            chk_val({done_f, err_f}, 2'b00);
        end
        chk_val({warn_led, ctrl_error_code}, 17'h10021);
        chk_flag(ctrl_halt, 1'b0);
        // Codes other than 1 must leave the sequencer idle
        wr(0, 16'h0002);
        run(1'b0, 16'h0000);
        chk_flag(busy, 1'b0);
        wr(0, 16'h0000);
        run(1'b1, 16'h0000);
        chk_val({busy, fcnt}, 17'h00000);
        // Second reset, then power-up path with halt selected
        rst = 1'b1;
        @(negedge ref_clk);
        rst = 1'b0;
        chk_val({warn_led, ctrl_halt, cmd}, 18'h00000);
        halt_on_error = 1'b1;
        fail_sel = 16'h0002;
        wr(1, 16'h0002);
        wr(0, 16'h0001);
        run(1'b1, 16'h0002);
        chk_flag(t_req >= 20 && t_req <= 26, 1'b1);
        chk_val({fcnt, oct}, 32'h00010002);
        chk_val({err_f, ctrl_halt, warn_led}, 3'b111);
        wrap_up();
    end
endmodule
